// *** core/scfg_strap_cfg.sv ***
// Purpose: Strap sampling, unit address decode and configuration unlock of an I/O controller
// Assumes: Host I/O strobes are one cycle long and synchronous to sys_clk_i
// Notes: Strap options drive the units directly, except that register writes set the floppy unit while its enable strap is low
`timescale 1ns/1ps
module scfg_strap_cfg
    import scfg_pkg::*;
#(
    parameter logic [7:0] ID_VALUE = 8'h5A, // Arbitrary identity value
    parameter logic [7:0] REV_VALUE = 8'h01 // Arbitrary revision value
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Strap pins
    input wire logic par_addr_strap_hi_i,
    input wire logic par_addr_strap_lo_i,
    input wire logic extended_cap_strap_i,
    input wire logic par_mode_strap_i,
    input wire logic ser_a_strap_hi_i,
    input wire logic ser_a_strap_lo_i,
    input wire logic ser_b_strap_hi_i,
    input wire logic ser_b_strap_lo_i,
    input wire logic disk_if_enable_strap_i,
    input wire logic disk_if_addr_strap_i,
    input wire logic floppy_enable_strap_i,
    input wire logic floppy_addr_strap_i,
    // Host I/O port
    input wire logic [9:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    output logic [7:0] io_rdata_o,
    output logic io_rack_o,
    // Unit selects for the current I/O cycle
    output logic par_cs_o,
    output logic ser_a_cs_o,
    output logic ser_b_cs_o,
    output logic disk_if_cs_o,
    output logic floppy_cs_o,
    // Resolved configuration
    output logic straps_valid_o,
    output logic par_en_o,
    output logic [9:0] par_base_o,
    output logic [1:0] par_mode_o,
    output logic ser_a_en_o,
    output logic [9:0] ser_a_base_o,
    output logic ser_b_en_o,
    output logic [9:0] ser_b_base_o,
    output logic disk_if_en_o,
    output logic disk_if_sec_o,
    output logic floppy_en_o,
    output logic floppy_sec_o,
    output logic data_rate_pins_oe_o,
    output logic floppy_mode2_ok_o,
    output logic floppy_mode2_sel_o,
    output logic [9:0] cfg_sel_port_o,
    output logic cfg_mode_o
);

    typedef struct packed {
        logic [1:0] settle_cnt;
        logic captured;
        scfg_strap_s strap_meta;
        scfg_strap_s strap_sync;
        scfg_strap_s strap;
        logic [15:0][7:0] cr;
        logic [3:0] index;
        logic [7:0] rdata;
        logic rack;
    } scfg_top_s;

    scfg_top_s st_r;
    scfg_top_s st_nxt;
    logic [1:0] rst_sync_r;
    logic rst_n_sync;
    scfg_strap_s strap_pins;
    logic [9:0] sel_port;
    logic sel_hit;
    logic data_hit;
    logic io_any;
    logic cfg_mode;

    scfg_key_if key_if ();

    function automatic logic in_range(input logic [9:0] addr, input logic [9:0] base,
                                      input logic [3:0] span);
        logic [9:0] off;
        off = addr - base;
        return (addr >= base) && (off < {6'd0, span});
    endfunction

    function automatic logic [9:0] ser_a_base(input logic [1:0] code);
        case (code)
            2'b01: return SCFG_SER_3E8;
            2'b10: return SCFG_SER_2F8;
            default: return SCFG_SER_3F8;
        endcase
    endfunction

    function automatic logic [9:0] ser_b_base(input logic [1:0] code);
        case (code)
            2'b01: return SCFG_SER_2E8;
            2'b10: return SCFG_SER_3F8;
            default: return SCFG_SER_2F8;
        endcase
    endfunction

    assign strap_pins = '{
        par_hi: par_addr_strap_hi_i, par_lo: par_addr_strap_lo_i,
        ecp: extended_cap_strap_i, par_mode: par_mode_strap_i,
        sa_hi: ser_a_strap_hi_i, sa_lo: ser_a_strap_lo_i,
        sb_hi: ser_b_strap_hi_i, sb_lo: ser_b_strap_lo_i,
        ide_en: disk_if_enable_strap_i, ide_addr: disk_if_addr_strap_i,
        fen: floppy_enable_strap_i, faddr: floppy_addr_strap_i
    };

    // Reset release goes through its own two stages; the rest runs on the copy.
    // Kept outside the state struct, which resets on this copy, so each has one driver
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_sync_r[1];

    // Select port moves to 370H only for floppy straps 01
    assign sel_port = (!st_r.strap.fen && st_r.strap.faddr) ? SCFG_SEL_SEC : SCFG_SEL_PRI;
    assign sel_hit = (io_addr_i == sel_port);
    assign data_hit = (io_addr_i == sel_port + 10'd1);
    assign io_any = io_wr_i || io_rd_i;

    assign key_if.wr_stb = io_wr_i && st_r.captured;
    assign key_if.sel_hit = sel_hit;
    assign key_if.wr_data = io_wdata_i;
    assign cfg_mode = key_if.cfg_mode;

    scfg_key_fsm u_key (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_sync),
        .key_if(key_if)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.strap_meta = strap_pins;
        st_nxt.strap_sync = st_r.strap_meta;
        st_nxt.rack = 1'b0;
        st_nxt.rdata = SCFG_RD_IDLE;
        // Sample once, after the synchroniser has filled, then freeze
        if (!st_r.captured) begin
            if (st_r.settle_cnt == SCFG_STRAP_SETTLE_CYC) begin
                st_nxt.strap = st_r.strap_sync;
                st_nxt.captured = 1'b1;
            end else begin
                st_nxt.settle_cnt = st_r.settle_cnt + 2'd1;
            end
        end
        // Index and register access only while unlocked
        if (io_wr_i && cfg_mode) begin
            if (sel_hit && io_wdata_i != SCFG_EXIT_CODE && io_wdata_i[7:4] == 4'h0) begin
                st_nxt.index = io_wdata_i[3:0];
            end else if (data_hit && st_r.index != SCFG_IDX_ID
                         && st_r.index != SCFG_IDX_REV) begin
                st_nxt.cr[st_r.index] = io_wdata_i;
            end
        end
        if (io_rd_i && cfg_mode && (sel_hit || data_hit)) begin
            st_nxt.rack = 1'b1;
            if (sel_hit) begin
                st_nxt.rdata = {4'h0, st_r.index};
            end else if (st_r.index == SCFG_IDX_ID) begin
                st_nxt.rdata = ID_VALUE;
            end else if (st_r.index == SCFG_IDX_REV) begin
                st_nxt.rdata = REV_VALUE;
            end else begin
                st_nxt.rdata = st_r.cr[st_r.index];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            st_r.settle_cnt <= 2'd0;
            st_r.captured <= 1'b0;
            st_r.strap_meta <= SCFG_STRAP_RESET;
            st_r.strap_sync <= SCFG_STRAP_RESET;
            st_r.strap <= SCFG_STRAP_RESET;
            st_r.cr <= {16{SCFG_CR_RESET}};
            st_r.index <= SCFG_IDX_RESET;
            st_r.rdata <= SCFG_RD_IDLE;
            st_r.rack <= 1'b0;
        end else begin
            st_r.settle_cnt <= st_nxt.settle_cnt;
            st_r.captured <= st_nxt.captured;
            st_r.strap_meta <= st_nxt.strap_meta;
            st_r.strap_sync <= st_nxt.strap_sync;
            st_r.strap <= st_nxt.strap;
            st_r.cr <= st_nxt.cr;
            st_r.index <= st_nxt.index;
            st_r.rdata <= st_nxt.rdata;
            st_r.rack <= st_nxt.rack;
        end
    end

    // Parallel port: base and mode come only from straps
    always_comb begin
        par_en_o = st_r.captured && (st_r.strap.par_hi || st_r.strap.par_lo);
        case ({st_r.strap.par_hi, st_r.strap.par_lo})
            2'b01: par_base_o = SCFG_PAR_BASE_1;
            2'b10: par_base_o = SCFG_PAR_BASE_2;
            default: par_base_o = SCFG_PAR_BASE_3;
        endcase
    end
    // 00 printer, 01 EPP, 10 ECP, 11 ECP plus EPP
    assign par_mode_o = {st_r.strap.ecp, st_r.strap.par_mode};

    // Serial ports
    assign ser_a_en_o = st_r.captured && (st_r.strap.sa_hi || st_r.strap.sa_lo);
    assign ser_a_base_o = ser_a_base({st_r.strap.sa_hi, st_r.strap.sa_lo});
    assign ser_b_en_o = st_r.captured && (st_r.strap.sb_hi || st_r.strap.sb_lo);
    assign ser_b_base_o = ser_b_base({st_r.strap.sb_hi, st_r.strap.sb_lo});

    // Disk interface: code 01 is reserved and treated as disabled
    assign disk_if_en_o = st_r.captured && st_r.strap.ide_en;
    assign disk_if_sec_o = st_r.strap.ide_addr;

    // Floppy: straps win when enabled, otherwise configuration registers decide
    assign floppy_en_o = st_r.captured && (st_r.strap.fen
                         || st_r.cr[SCFG_IDX_FDC][SCFG_FDC_EN_BIT]);
    assign floppy_sec_o = st_r.strap.fen ? st_r.strap.faddr
                          : st_r.cr[SCFG_IDX_FDC][SCFG_FDC_SEC_BIT];
    assign data_rate_pins_oe_o = st_r.captured && st_r.strap.fen;
    assign floppy_mode2_ok_o = st_r.captured && !st_r.strap.fen;
    assign floppy_mode2_sel_o = floppy_mode2_ok_o
                                && st_r.cr[SCFG_IDX_MODE][SCFG_MODE2_BIT];

    // Unit selects: a disabled unit never sees its cycle
    assign par_cs_o = io_any && par_en_o && in_range(io_addr_i, par_base_o,
                      (par_base_o == SCFG_PAR_BASE_1) ? SCFG_PAR_SPAN_1 : SCFG_PAR_SPAN);
    assign ser_a_cs_o = io_any && ser_a_en_o
                        && in_range(io_addr_i, ser_a_base_o, SCFG_SER_SPAN);
    assign ser_b_cs_o = io_any && ser_b_en_o
                        && in_range(io_addr_i, ser_b_base_o, SCFG_SER_SPAN);
    assign disk_if_cs_o = io_any && disk_if_en_o && (disk_if_sec_o
        ? (in_range(io_addr_i, SCFG_IDE_SEC, SCFG_UNIT_SPAN)
           || in_range(io_addr_i, SCFG_IDE_SEC_AUX, SCFG_AUX_SPAN))
        : (in_range(io_addr_i, SCFG_IDE_PRI, SCFG_UNIT_SPAN)
           || in_range(io_addr_i, SCFG_IDE_PRI_AUX, SCFG_AUX_SPAN)));
    assign floppy_cs_o = io_any && floppy_en_o && in_range(io_addr_i,
        floppy_sec_o ? SCFG_FDC_SEC : SCFG_FDC_PRI, SCFG_UNIT_SPAN);

    assign straps_valid_o = st_r.captured;
    assign cfg_sel_port_o = sel_port;
    assign cfg_mode_o = cfg_mode;
    assign io_rdata_o = st_r.rdata;
    assign io_rack_o = st_r.rack;

endmodule // scfg_strap_cfg

// *** include/scfg_pkg.sv ***
// Purpose: Shared constants and types for the strap configuration and unlock block
// Assumes: 10-bit I/O addresses, 8-bit I/O data
// Notes: Identity and revision values are parameters of the top module
package scfg_pkg;

    // Configuration port locations
    localparam logic [9:0] SCFG_SEL_PRI = 10'h3F0;
    localparam logic [9:0] SCFG_SEL_SEC = 10'h370;

    // Unlock and exit codes written to the select port
    localparam logic [7:0] SCFG_KEY_CODE = 8'h44;
    localparam logic [7:0] SCFG_EXIT_CODE = 8'hAA;

    // Parallel port bases by strap code 01, 10, 11
    localparam logic [9:0] SCFG_PAR_BASE_1 = 10'h3BC;
    localparam logic [9:0] SCFG_PAR_BASE_2 = 10'h378;
    localparam logic [9:0] SCFG_PAR_BASE_3 = 10'h278;
    localparam logic [3:0] SCFG_PAR_SPAN_1 = 4'h4;
    localparam logic [3:0] SCFG_PAR_SPAN = 4'h8;

    // Serial port bases
    localparam logic [9:0] SCFG_SER_3E8 = 10'h3E8;
    localparam logic [9:0] SCFG_SER_2F8 = 10'h2F8;
    localparam logic [9:0] SCFG_SER_3F8 = 10'h3F8;
    localparam logic [9:0] SCFG_SER_2E8 = 10'h2E8;
    localparam logic [3:0] SCFG_SER_SPAN = 4'h8;

    // Floppy and disk interface windows
    localparam logic [9:0] SCFG_FDC_PRI = 10'h3F0;
    localparam logic [9:0] SCFG_FDC_SEC = 10'h370;
    localparam logic [9:0] SCFG_IDE_PRI = 10'h1F0;
    localparam logic [9:0] SCFG_IDE_SEC = 10'h170;
    localparam logic [9:0] SCFG_IDE_PRI_AUX = 10'h3F6;
    localparam logic [9:0] SCFG_IDE_SEC_AUX = 10'h376;
    localparam logic [3:0] SCFG_UNIT_SPAN = 4'h8;
    localparam logic [3:0] SCFG_AUX_SPAN = 4'h2;

    // Configuration register indices and fields
    localparam logic [3:0] SCFG_IDX_FDC = 4'h0;
    localparam int SCFG_FDC_EN_BIT = 0;
    localparam int SCFG_FDC_SEC_BIT = 1;
    localparam logic [3:0] SCFG_IDX_MODE = 4'h1;
    localparam int SCFG_MODE2_BIT = 0;
    localparam logic [3:0] SCFG_IDX_ID = 4'hD;
    localparam logic [3:0] SCFG_IDX_REV = 4'hE;

    // Reset values
    localparam logic [7:0] SCFG_CR_RESET = 8'h00;
    localparam logic [3:0] SCFG_IDX_RESET = 4'h0;
    localparam logic [7:0] SCFG_RD_IDLE = 8'h00;

    // Cycles from reset release until strap samples have crossed the synchroniser
    localparam logic [1:0] SCFG_STRAP_SETTLE_CYC = 2'd2;

    typedef enum logic [2:0] {
        SCFG_KEY_IDLE = 3'b001,
        SCFG_KEY_ONE = 3'b010,
        SCFG_KEY_CFG = 3'b100
    } scfg_key_state_e;

    typedef struct packed {
        logic par_hi;
        logic par_lo;
        logic ecp;
        logic par_mode;
        logic sa_hi;
        logic sa_lo;
        logic sb_hi;
        logic sb_lo;
        logic ide_en;
        logic ide_addr;
        logic fen;
        logic faddr;
    } scfg_strap_s;

    localparam scfg_strap_s SCFG_STRAP_RESET = '0;

endpackage

// *** include/scfg_key_if.sv ***
// Purpose: Carries host write events from the top to the unlock detector
// Assumes: One clock domain
// Notes: sel_hit is already qualified with the active select port
`timescale 1ns/1ps
interface scfg_key_if;
    logic wr_stb;
    logic sel_hit;
    logic [7:0] wr_data;
    logic cfg_mode;

    modport top (output wr_stb, output sel_hit, output wr_data, input cfg_mode);
    modport key (input wr_stb, input sel_hit, input wr_data, output cfg_mode);
endinterface

// *** core/scfg_key_fsm.sv ***
// Purpose: Unlock sequence detector for configuration mode
// Assumes: Write strobes are one cycle long and synchronous to sys_clk_i
// Notes: Reads never disturb the sequence, only writes do
`timescale 1ns/1ps
module scfg_key_fsm
    import scfg_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Host write events
    scfg_key_if.key key_if
);

    typedef struct packed {
        scfg_key_state_e state;
    } scfg_key_s;

    scfg_key_s st_r;
    scfg_key_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (key_if.wr_stb) begin
            case (st_r.state)
                SCFG_KEY_IDLE: begin
                    if (key_if.sel_hit && key_if.wr_data == SCFG_KEY_CODE) begin
                        st_nxt.state = SCFG_KEY_ONE;
                    end
                end
                SCFG_KEY_ONE: begin
                    // Any other write, anywhere, breaks the pair
                    if (key_if.sel_hit && key_if.wr_data == SCFG_KEY_CODE) begin
                        st_nxt.state = SCFG_KEY_CFG;
                    end else begin
                        st_nxt.state = SCFG_KEY_IDLE;
                    end
                end
                SCFG_KEY_CFG: begin
                    if (key_if.sel_hit && key_if.wr_data == SCFG_EXIT_CODE) begin
                        st_nxt.state = SCFG_KEY_IDLE;
                    end
                end
                default: begin
                    st_nxt.state = SCFG_KEY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r.state <= SCFG_KEY_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign key_if.cfg_mode = (st_r.state == SCFG_KEY_CFG);

endmodule // scfg_key_fsm

// *** tb/scfg_strap_cfg_properties.sv ***
// Purpose: Port-level properties of the strap configuration block
// Assumes: One clock, reset active low
// Notes: Bound to the top module from the testbench file
`timescale 1ns/1ps
module scfg_strap_cfg_chk
    import scfg_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [9:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic io_rack_o,
    input wire logic par_cs_o,
    input wire logic par_en_o,
    input wire logic [9:0] par_base_o,
    input wire logic [9:0] ser_a_base_o,
    input wire logic straps_valid_o,
    input wire logic floppy_en_o,
    input wire logic data_rate_pins_oe_o,
    input wire logic floppy_mode2_ok_o,
    input wire logic floppy_mode2_sel_o,
    input wire logic [9:0] cfg_sel_port_o,
    input wire logic cfg_mode_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_rack_cause: assert property (
        io_rack_o |-> $past(io_rd_i) && $past(cfg_mode_o))
        else $error("read answered outside configuration mode");
    a_rdata_quiet: assert property (
        !io_rack_o |-> io_rdata_o == SCFG_RD_IDLE)
        else $error("read data driven without a claimed read");
    a_key_entry: assert property (
        $rose(cfg_mode_o) |-> $past(io_wr_i && io_addr_i == cfg_sel_port_o
            && io_wdata_i == SCFG_KEY_CODE))
        else $error("configuration mode entered without a key write");
    a_exit_code: assert property (
        cfg_mode_o && io_wr_i && io_addr_i == cfg_sel_port_o
            && io_wdata_i == SCFG_EXIT_CODE |=> !cfg_mode_o)
        else $error("exit code did not leave configuration mode");
    a_straps_frozen: assert property (
        straps_valid_o && $past(straps_valid_o) |-> $stable(par_base_o)
            && $stable(ser_a_base_o) && $stable(data_rate_pins_oe_o))
        else $error("strap-derived setting moved after capture");
    a_par_cs_gate: assert property (
        par_cs_o |-> par_en_o && (io_wr_i || io_rd_i))
        else $error("parallel select without enable or strobe");
    a_rate_pins_fixed: assert property (
        data_rate_pins_oe_o |-> floppy_en_o && !floppy_mode2_ok_o && !floppy_mode2_sel_o)
        else $error("floppy strap high but floppy not fixed on");
    a_alt_select: assert property (
        cfg_sel_port_o == SCFG_SEL_SEC |-> straps_valid_o && !data_rate_pins_oe_o)
        else $error("select port moved while floppy strap high");
    a_mode2_gate: assert property (
        floppy_mode2_sel_o |-> floppy_mode2_ok_o)
        else $error("enhanced mode two selected while not allowed");
endmodule // scfg_strap_cfg_chk

// *** tb/scfg_host_model.sv ***
// Purpose: Host processor model issuing one-cycle I/O strobes
// Assumes: Strobes launched by non-blocking assignment after a rising edge
// Notes: Address and data show inverted junk between cycles
`timescale 1ns/1ps
module scfg_host_model (
    // Clock
    input wire logic sys_clk_i,
    // I/O cycle
    output logic [9:0] io_addr_o,
    output logic [7:0] io_wdata_o,
    output logic io_wr_o,
    output logic io_rd_o
);
    initial begin
        io_addr_o = 10'h000;
        io_wdata_o = 8'h00;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
    end

    // One transfer at a time, so nothing slips between key writes
    task automatic cyc(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        io_addr_o <= a;
        io_wdata_o <= d;
        io_wr_o <= w;
        io_rd_o <= !w;
        @(posedge sys_clk_i);
        io_wr_o <= 1'b0;
        io_rd_o <= 1'b0;
        io_addr_o <= ~a;
        io_wdata_o <= ~d;
    endtask
endmodule // scfg_host_model

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the strap configuration block
// Assumes: Host model owns the I/O port
// Notes: Parallel and floppy strap codes swept, other straps random
`timescale 1ns/1ps
module testbench;
    import scfg_pkg::*;
    localparam logic [7:0] ID_V = 8'hC3; // Arbitrary identity value
    localparam logic [7:0] REV_V = 8'h2D; // Arbitrary revision value
    localparam logic [9:0] PICK [16] = '{10'h3BC, 10'h3BF, 10'h3C0, 10'h27F, 10'h3E8,
        10'h2FF, 10'h3F8, 10'h2E8, 10'h1F0, 10'h1F7, 10'h3F6, 10'h377, 10'h170, 10'h3F7,
        10'h370, 10'h378};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    scfg_strap_s strap = '0;
    scfg_strap_s lat, s;
    logic [9:0] io_addr, par_base, sa_base, sb_base, sel, sel_x, addr_pick;
    logic [7:0] io_wdata, rdata;
    logic [4:0] cs;
    logic [1:0] par_mode;
    logic [10:0] p_x, s1_x, s2_x;
    logic io_wr, io_rd, rack, valid, cfg_mode, oe, m2ok, m2sel, fen_x, fsec_x;
    logic par_en, sa_en, sb_en, dk_en, dk_sec, f_en, f_sec;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 19104;

    scfg_host_model host (.sys_clk_i(sys_clk), .io_addr_o(io_addr), .io_wdata_o(io_wdata),
        .io_wr_o(io_wr), .io_rd_o(io_rd));
    scfg_strap_cfg #(.ID_VALUE(ID_V), .REV_VALUE(REV_V)) uut (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n),
        .par_addr_strap_hi_i(strap.par_hi), .par_addr_strap_lo_i(strap.par_lo),
        .extended_cap_strap_i(strap.ecp), .par_mode_strap_i(strap.par_mode),
        .ser_a_strap_hi_i(strap.sa_hi), .ser_a_strap_lo_i(strap.sa_lo),
        .ser_b_strap_hi_i(strap.sb_hi), .ser_b_strap_lo_i(strap.sb_lo),
        .disk_if_enable_strap_i(strap.ide_en), .disk_if_addr_strap_i(strap.ide_addr),
        .floppy_enable_strap_i(strap.fen), .floppy_addr_strap_i(strap.faddr),
        .io_addr_i(io_addr), .io_wdata_i(io_wdata), .io_wr_i(io_wr), .io_rd_i(io_rd),
        .io_rdata_o(rdata), .io_rack_o(rack), .par_cs_o(cs[4]), .ser_a_cs_o(cs[3]),
        .ser_b_cs_o(cs[2]), .disk_if_cs_o(cs[1]), .floppy_cs_o(cs[0]),
        .straps_valid_o(valid), .par_en_o(par_en), .par_base_o(par_base),
        .par_mode_o(par_mode), .ser_a_en_o(sa_en), .ser_a_base_o(sa_base),
        .ser_b_en_o(sb_en), .ser_b_base_o(sb_base), .disk_if_en_o(dk_en),
        .disk_if_sec_o(dk_sec), .floppy_en_o(f_en), .floppy_sec_o(f_sec),
        .data_rate_pins_oe_o(oe), .floppy_mode2_ok_o(m2ok), .floppy_mode2_sel_o(m2sel),
        .cfg_sel_port_o(sel), .cfg_mode_o(cfg_mode));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Returns {enable, base} for a two-strap address code
    function automatic logic [10:0] base_x(input logic [1:0] c, input logic [9:0] b1,
                                           input logic [9:0] b2, input logic [9:0] b3);
        case (c)
            2'b01: return {1'b1, b1};
            2'b10: return {1'b1, b2};
            2'b11: return {1'b1, b3};
            default: return 11'h000;
        endcase
    endfunction

    function automatic logic [4:0] cs_x(input logic [9:0] a);
        logic [9:0] dk, aux;
        dk = lat.ide_addr ? SCFG_IDE_SEC : SCFG_IDE_PRI;
        aux = lat.ide_addr ? SCFG_IDE_SEC_AUX : SCFG_IDE_PRI_AUX;
        cs_x[4] = p_x[10] && a >= p_x[9:0]
            && a < p_x[9:0] + ((p_x[9:0] == SCFG_PAR_BASE_1) ? 10'd4 : 10'd8);
        cs_x[3] = s1_x[10] && a[9:3] == s1_x[9:3];
        cs_x[2] = s2_x[10] && a[9:3] == s2_x[9:3];
        cs_x[1] = lat.ide_en && (a[9:3] == dk[9:3] || a[9:1] == aux[9:1]);
        cs_x[0] = fen_x && a[9:3] == (fsec_x ? SCFG_FDC_SEC[9:3] : SCFG_FDC_PRI[9:3]);
    endfunction

    task automatic check_cfg();
        check(16'({par_en, par_en ? par_base : 10'h000}), 16'(p_x));
        check(16'(par_mode), 16'({lat.ecp, lat.par_mode}));
        check(16'({sa_en, sa_en ? sa_base : 10'h000}), 16'(s1_x));
        check(16'({sb_en, sb_en ? sb_base : 10'h000}), 16'(s2_x));
        check(16'({dk_en, dk_en & dk_sec}), 16'({lat.ide_en, lat.ide_en & lat.ide_addr}));
        check(16'({f_en, f_en & f_sec, oe, m2ok}), 16'({fen_x, fsec_x, lat.fen, !lat.fen}));
        check(16'(sel), 16'(sel_x));
    endtask

    // Strobe decode and read answers checked as the host issues cycles
    always @(posedge sys_clk) begin
        #1;
        if (io_wr === 1'b1 || io_rd === 1'b1) begin
            check(16'(cs), 16'(cs_x(io_addr)));
        end
        if (rack !== 1'b0) begin
            if (exp_q.size() > 0) begin
                check(16'(rdata), 16'(exp_q.pop_front()));
            end else begin
                check(16'(rack), 16'h0000);
            end
        end
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        for (int i = 0; i < 16; i++) begin
            s = scfg_strap_s'(12'($random(seed)));
            {s.par_hi, s.par_lo, s.fen, s.faddr} = 4'(i);
            @(posedge sys_clk);
            strap <= s;
            rst_n <= 1'b0;
            repeat (5) @(posedge sys_clk);
            rst_n <= 1'b1;
            lat = s;
            fen_x = s.fen;
            fsec_x = s.fen & s.faddr;
            sel_x = (!s.fen && s.faddr) ? SCFG_SEL_SEC : SCFG_SEL_PRI;
            p_x = base_x({s.par_hi, s.par_lo}, SCFG_PAR_BASE_1, SCFG_PAR_BASE_2, SCFG_PAR_BASE_3);
            s1_x = base_x({s.sa_hi, s.sa_lo}, SCFG_SER_3E8, SCFG_SER_2F8, SCFG_SER_3F8);
            s2_x = base_x({s.sb_hi, s.sb_lo}, SCFG_SER_2E8, SCFG_SER_3F8, SCFG_SER_2F8);
            for (int k = 0; k < 20 && valid !== 1'b1; k++) @(posedge sys_clk);
            if (valid !== 1'b1) begin
                n_mismatch++;
                end_of_test();
            end
            @(negedge sys_clk);
            check_cfg();
            strap <= scfg_strap_s'(~s);
            repeat (4) @(posedge sys_clk);
            @(negedge sys_clk);
            check_cfg();
            host.cyc(1'b1, sel_x, SCFG_KEY_CODE);
            host.cyc(1'b1, 10'h080, SCFG_KEY_CODE);
            host.cyc(1'b1, sel_x, SCFG_KEY_CODE);
            @(negedge sys_clk);
            check(16'(cfg_mode), 16'h0000);
            host.cyc(1'b1, sel_x, 8'h01);
            host.cyc(1'b1, sel_x, SCFG_KEY_CODE);
            host.cyc(1'b0, sel_x + 10'd1, 8'h00);
            @(negedge sys_clk);
            check(16'(cfg_mode), 16'h0000);
            host.cyc(1'b1, sel_x, SCFG_KEY_CODE);
            @(negedge sys_clk);
            check(16'(cfg_mode), 16'h0001);
            exp_q.push_back(ID_V);
            host.cyc(1'b1, sel_x, {4'h0, SCFG_IDX_ID});
            host.cyc(1'b0, sel_x + 10'd1, 8'h00);
            exp_q.push_back(REV_V);
            exp_q.push_back({4'h0, SCFG_IDX_REV});
            host.cyc(1'b1, sel_x, {4'h0, SCFG_IDX_REV});
            // Revision register is read only: this write must not show
            host.cyc(1'b1, sel_x + 10'd1, 8'h55);
            host.cyc(1'b0, sel_x + 10'd1, 8'h00);
            host.cyc(1'b0, sel_x, 8'h00);
            host.cyc(1'b1, sel_x, {4'h0, SCFG_IDX_FDC});
            host.cyc(1'b1, sel_x + 10'd1, 8'h03);
            fen_x = lat.fen | 1'b1;
            fsec_x = lat.fen ? lat.faddr : 1'b1;
            exp_q.push_back(8'h03);
            host.cyc(1'b0, sel_x + 10'd1, 8'h00);
            host.cyc(1'b1, sel_x, {4'h0, SCFG_IDX_MODE});
            host.cyc(1'b1, sel_x + 10'd1, 8'h01);
            @(negedge sys_clk);
            check_cfg();
            check(16'(m2sel), 16'(!lat.fen));
            host.cyc(1'b1, sel_x, SCFG_EXIT_CODE);
            @(negedge sys_clk);
            check(16'(cfg_mode), 16'h0000);
            repeat (12) begin
                addr_pick = 10'($random(seed));
                if (addr_pick[0]) addr_pick = PICK[addr_pick[4:1]];
                host.cyc(1'b0, addr_pick, 8'h00);
            end
            repeat (2) @(posedge sys_clk);
            check(16'(exp_q.size()), 16'h0000);
            $display("test %0d done", i);
        end
        end_of_test();
    end
endmodule // testbench

bind scfg_strap_cfg scfg_strap_cfg_chk chk (.sys_clk_i, .rst_n_i, .io_addr_i, .io_wdata_i,
    .io_wr_i, .io_rd_i, .io_rdata_o, .io_rack_o, .par_cs_o, .par_en_o, .par_base_o,
    .ser_a_base_o, .straps_valid_o, .floppy_en_o, .data_rate_pins_oe_o, .floppy_mode2_ok_o,
    .floppy_mode2_sel_o, .cfg_sel_port_o, .cfg_mode_o);
